/* mld_pkg.sv */
// package for the matrix led dimmer core: register map, field layout, reset values
// Notes on behaviour
// - open threshold per channel, four levels, highest level after reset
// - open fault while enabled: switch on, dimming suspended until software clears
// - short detector counts one to four shorts, one short after reset
// - short fault leaves the programmed dimming running unchanged
// - over-temperature is latched as a reportable fault with the led faults
// - alert pulled low when any led or overheat fault is detected while enabled
// - nine writable command registers, two read-only fault registers, all readable
// - registers reachable in any order; four address bits select one of sixteen
// - dimming rate is pwm clock over 2048; external clock overrides internal
// - bus works while disabled; writes then are discarded when enable rises
// - disabled: all switches off, alert inactive
// - enable rising edge reloads defaults, all switches off, leds lit
// - reset staggers channel counters by one eighth of a dimming cycle
// - dimming: lit at cycle start, dark once counter equals value, till next cycle
// - without fade the new value takes effect within one dimming cycle
// - single-channel dimming value is replaced only at the ending stop condition
// - fade steps computed at 11 bits, times 1.0625 rising, 0.9375 falling
// - fade starts at stored value, ends at target once step reaches or passes it
// - each fade step lasts four dimming cycles, 8192 pwm clocks
// - full range fade takes at most 97 steps up, 92 steps down
// - all-channel address 010 plus select bits, single-channel 101 plus select bits
// - mode field: 00 off, 01 on, 10 dimming, 11 dimming with fade
// - alert released after alert response or when faults cleared by write
// - switch follows last written of all-channel or single-channel register
package mld_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned ADDR_W = 8;
  // apb byte addresses, one word each
  localparam logic [7:0] OFF_CFG0 = 8'h00; // channel_config_reg 0..7 at 0x00..0x1c
  localparam logic [7:0] OFF_ONOFF = 8'h20;
  localparam logic [7:0] OFF_FLT_OPEN = 8'h24;
  localparam logic [7:0] OFF_FLT_SHORT = 8'h28;
  localparam logic [7:0] OFF_FLT_CLR = 8'h2c;
  localparam logic [7:0] OFF_COMMIT = 8'h30;
  localparam logic [7:0] OFF_STATUS = 8'h34;
  localparam logic [7:0] OFF_ARA = 8'h38;
  // channel_config_reg fields
  localparam int unsigned DV_LSB = 0;
  localparam int unsigned MODE_LSB = 8;
  localparam int unsigned STH_LSB = 10;
  localparam int unsigned OTH_LSB = 12;
  localparam int unsigned CFG_W = 14;
  localparam logic [13:0] CFG_RESET = 14'h3101;
  localparam logic [7:0] ONOFF_RESET = 8'hff;
  // channel_mode_field encodings
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] MODE_DIM = 2'h2;
  localparam logic [1:0] MODE_FADE = 2'h3;
  // dimming cycle and fade timing in pwm clock ticks
  localparam int unsigned CYCLE_TICKS = 2048;
  localparam int unsigned CNT_W = 11;
  localparam int unsigned STEP_CYCLES = 4;
  localparam int unsigned STAGGER = CYCLE_TICKS / NUM_CH;
  localparam int unsigned FADE_W = 11;
  // slave address prefixes
  localparam logic [2:0] ADR_ALL = 3'h2;
  localparam logic [2:0] ADR_ONE = 3'h5;
endpackage : mld_pkg

/* mld_core.sv */
// matrix led pwm dimmer core with apb register access
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mld_core #(
  parameter int unsigned NUM_CH = mld_pkg::NUM_CH
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic enable_input,
  input wire logic pwm_clock_pin,
  input wire logic ext_clock_sel,
  input wire logic int_osc_tick,
  input wire logic [3:0] addr_select,
  // analog fault detectors
  input wire logic [NUM_CH-1:0] open_detect,
  input wire logic [NUM_CH-1:0] short_detect,
  input wire logic overheat_detect,
  // outputs
  output logic [NUM_CH-1:0] bypass_switch,
  output logic [1:0] open_threshold_select [NUM_CH],
  output logic [1:0] short_threshold_select [NUM_CH],
  output logic alert_n_o,
  output logic alert_n_oe
);
  // synchronisers for pins
  logic [1:0] en_s, pck_s, sel_s, osc_s, ot_s;
  logic [NUM_CH-1:0] op_s0, op_s1, sh_s0, sh_s1;
  // address pins are straps but may still move while the bus is read
  logic [3:0] as_s0, as_s1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_s <= 2'h0;
      pck_s <= 2'h0;
      sel_s <= 2'h0;
      osc_s <= 2'h0;
      ot_s <= 2'h0;
      op_s0 <= '0;
      op_s1 <= '0;
      sh_s0 <= '0;
      sh_s1 <= '0;
      as_s0 <= 4'h0;
      as_s1 <= 4'h0;
    end else begin
      en_s <= {en_s[0], enable_input};
      pck_s <= {pck_s[0], pwm_clock_pin};
      sel_s <= {sel_s[0], ext_clock_sel};
      osc_s <= {osc_s[0], int_osc_tick};
      ot_s <= {ot_s[0], overheat_detect};
      op_s0 <= open_detect;
      op_s1 <= op_s0;
      sh_s0 <= short_detect;
      sh_s1 <= sh_s0;
      as_s0 <= addr_select;
      as_s1 <= as_s0;
    end
  end
  wire enabled = en_s[1];
  logic en_d, pck_d, osc_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_d <= 1'b0;
      pck_d <= 1'b0;
      osc_d <= 1'b0;
    end else begin
      en_d <= en_s[1];
      pck_d <= pck_s[1];
      osc_d <= osc_s[1];
    end
  end
  wire por = enabled && !en_d;
  // external clock overrides the internal oscillator
  wire tick = sel_s[1] ? (pck_s[1] && !pck_d) : (osc_s[1] && !osc_d);

  // apb decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire is_cfg = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  wire [2:0] cidx = paddr[4:2];
  wire known = is_cfg || paddr == mld_pkg::OFF_ONOFF || paddr == mld_pkg::OFF_FLT_OPEN
    || paddr == mld_pkg::OFF_FLT_SHORT || paddr == mld_pkg::OFF_FLT_CLR
    || paddr == mld_pkg::OFF_COMMIT || paddr == mld_pkg::OFF_STATUS
    || paddr == mld_pkg::OFF_ARA;
  assign pready = 1'b1;
  assign pslverr = acc && !known;

  // registers
  logic [13:0] cfg_reg [NUM_CH];
  logic [7:0] pend_dv_reg [NUM_CH];
  logic [NUM_CH-1:0] pend_reg, sc_ctl_reg, open_flt_reg, short_flt_reg;
  logic [7:0] onoff_reg;
  logic ot_flt_reg, alert_reg;
  logic [10:0] cnt_reg [NUM_CH];
  logic [10:0] fade_reg [NUM_CH];
  logic [1:0] stepc_reg [NUM_CH];
  logic [NUM_CH-1:0] lit_reg;

  wire commit = wr && paddr == mld_pkg::OFF_COMMIT && pwdata[0]; // stop seen
  wire clr_wr = wr && paddr == mld_pkg::OFF_FLT_CLR;
  wire ara_rd = acc && !pwrite && paddr == mld_pkg::OFF_ARA;
  wire any_flt = |open_flt_reg || |short_flt_reg || ot_flt_reg;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gch
      wire cfg_wr = wr && is_cfg && cidx == 3'(g);
      wire [7:0] dv = cfg_reg[g][7:0];
      wire [1:0] md = cfg_reg[g][9:8];
      wire cyc_end = tick && cnt_reg[g] == 11'(mld_pkg::CYCLE_TICKS - 1);
      wire fading = md == mld_pkg::MODE_FADE;
      wire [11:0] up = {1'b0, fade_reg[g]} + {5'h0, fade_reg[g][10:4]};
      wire [10:0] dn = fade_reg[g] - {4'h0, fade_reg[g][10:4]};
      wire [10:0] tgt = {dv, 3'h0};
      wire rising = fade_reg[g] < tgt;
      // ensure motion when the 1/16 increment is below one lsb
      wire [11:0] up_s = (up[10:0] == fade_reg[g]) ? up + 12'h1 : up;
      wire [10:0] dn_s = (dn == fade_reg[g]) ? dn - 11'h1 : dn;
      // reach or pass the target ends the fade
      wire [10:0] nxt = rising ? ((up_s >= {1'b0, tgt}) ? tgt : up_s[10:0])
                               : ((dn_s <= tgt) ? tgt : dn_s);
      // fade compare uses the integer part
      wire [7:0] cmp = fading ? fade_reg[g][10:3] : dv;
      wire sc_drive = md == mld_pkg::MODE_ON ? 1'b0 : md == mld_pkg::MODE_OFF ? 1'b1 : !lit_reg[g];
      wire sw = sc_ctl_reg[g] ? sc_drive : !onoff_reg[g];
      // open fault bypasses, short fault keeps dimming, all switches off when disabled
      assign bypass_switch[g] = enabled && (open_flt_reg[g] || sw);
      assign open_threshold_select[g] = cfg_reg[g][13:12];
      assign short_threshold_select[g] = cfg_reg[g][11:10];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_reg[g] <= mld_pkg::CFG_RESET;
          pend_dv_reg[g] <= 8'h00;
          pend_reg[g] <= 1'b0;
          sc_ctl_reg[g] <= 1'b0;
          cnt_reg[g] <= 11'(g * mld_pkg::STAGGER);
          fade_reg[g] <= 11'h008;
          stepc_reg[g] <= 2'h0;
          lit_reg[g] <= 1'b1;
          open_flt_reg[g] <= 1'b0;
          short_flt_reg[g] <= 1'b0;
        end else if (por) begin // defaults and stagger
          cfg_reg[g] <= mld_pkg::CFG_RESET;
          pend_reg[g] <= 1'b0;
          sc_ctl_reg[g] <= 1'b0;
          cnt_reg[g] <= 11'(g * mld_pkg::STAGGER);
          fade_reg[g] <= 11'h008;
          stepc_reg[g] <= 2'h0;
          lit_reg[g] <= 1'b1;
          open_flt_reg[g] <= 1'b0;
          short_flt_reg[g] <= 1'b0;
        end else begin
          if (cfg_wr) begin
            cfg_reg[g][13:8] <= pwdata[13:8];
            pend_dv_reg[g] <= pwdata[7:0];
            pend_reg[g] <= 1'b1;
            sc_ctl_reg[g] <= 1'b1;
          end else if (commit && pend_reg[g]) begin
            cfg_reg[g][7:0] <= pend_dv_reg[g];
            pend_reg[g] <= 1'b0;
          end
          if (wr && paddr == mld_pkg::OFF_ONOFF) sc_ctl_reg[g] <= 1'b0;
          if (tick) begin
            cnt_reg[g] <= cnt_reg[g] + 11'h1; // 2048 ticks per cycle
            // lit at start, dark at compare, new value compared from the next tick
            if (cyc_end) lit_reg[g] <= 1'b1;
            else if (cnt_reg[g][10:3] == cmp) lit_reg[g] <= 1'b0;
          end
          if (!fading) begin
            fade_reg[g] <= tgt;
            stepc_reg[g] <= 2'h0;
          end else if (cyc_end) begin
            stepc_reg[g] <= stepc_reg[g] + 2'h1;
            // step every four cycles
            if (stepc_reg[g] == 2'(mld_pkg::STEP_CYCLES - 1) && fade_reg[g] != tgt)
              fade_reg[g] <= nxt;
          end
          // set wins over clear; latched only while enabled
          if (clr_wr && pwdata[g]) open_flt_reg[g] <= 1'b0;
          if (clr_wr && pwdata[8 + g]) short_flt_reg[g] <= 1'b0;
          if (enabled && op_s1[g]) open_flt_reg[g] <= 1'b1;
          if (enabled && sh_s1[g]) short_flt_reg[g] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      onoff_reg <= mld_pkg::ONOFF_RESET;
      ot_flt_reg <= 1'b0;
      alert_reg <= 1'b0;
    end else if (por) begin
      onoff_reg <= mld_pkg::ONOFF_RESET;
      ot_flt_reg <= 1'b0;
      alert_reg <= 1'b0;
    end else begin
      if (wr && paddr == mld_pkg::OFF_ONOFF) onoff_reg <= pwdata[7:0];
      if (clr_wr && pwdata[16]) ot_flt_reg <= 1'b0;
      if (enabled && ot_s[1]) ot_flt_reg <= 1'b1;
      // new fault raises alert; response or clear releases it
      if (enabled && (|op_s1 || |sh_s1 || ot_s[1])) alert_reg <= 1'b1;
      else if (ara_rd || clr_wr || !any_flt) alert_reg <= 1'b0;
    end
  end
  // open-drain alert, inactive when disabled
  assign alert_n_o = 1'b0;
  assign alert_n_oe = enabled && alert_reg;

  // read mux, all registers readable
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0;
    if (is_cfg) rd = {18'h0, cfg_reg[cidx]};
    else if (paddr == mld_pkg::OFF_ONOFF) rd = {24'h0, onoff_reg};
    else if (paddr == mld_pkg::OFF_FLT_OPEN) rd = {24'h0, open_flt_reg};
    else if (paddr == mld_pkg::OFF_FLT_SHORT) rd = {23'h0, ot_flt_reg, short_flt_reg};
    else if (paddr == mld_pkg::OFF_STATUS) rd = {22'h0, enabled, alert_reg, sc_ctl_reg};
    else if (paddr == mld_pkg::OFF_ARA) rd = {24'h0, mld_pkg::ADR_ALL, as_s1, 1'b1};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) prdata <= rd;
  end
endmodule : mld_core
`default_nettype wire

/* mld_core_asserts.sv */
// port-level checks for the matrix led dimmer core
`timescale 1ns/1ps
`default_nettype none
module mld_core_asserts #(
  parameter int unsigned NUM_CH = 8
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // pins
  input wire logic enable_input,
  input wire logic [NUM_CH-1:0] open_detect,
  input wire logic overheat_detect,
  input wire logic [NUM_CH-1:0] bypass_switch,
  input wire logic [1:0] open_threshold_select [NUM_CH],
  input wire logic [1:0] short_threshold_select [NUM_CH],
  input wire logic alert_n_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc;
  assign acc = psel && penable;
  unmapped_err_a: assert property (acc && paddr > 8'h38 |-> pslverr)
    else $error("unmapped access without error");
  thr_write_a: assert property (acc && pwrite && paddr == 8'h00 |=>
    open_threshold_select[0] == $past(pwdata[13:12])
    && short_threshold_select[0] == $past(pwdata[11:10]))
    else $error("threshold select not written");
  por_defaults_a: assert property ($rose(enable_input) |-> ##[2:6]
    (open_threshold_select[0] == 2'h3 && short_threshold_select[0] == 2'h0))
    else $error("defaults not reloaded on enable");
  off_quiet_a: assert property (!enable_input [*6] |->
    bypass_switch == '0 && !alert_n_oe) else $error("disabled core not quiet");
  heat_alert_a: assert property (enable_input [*8] ##1 overheat_detect [*4]
    |-> ##[0:3] alert_n_oe) else $error("overheat without alert");
  open_bypass_a: assert property (enable_input [*8] ##1 open_detect[3] [*4]
    |-> ##[0:3] bypass_switch[3]) else $error("open fault not bypassed");
  ara_release_a: assert property (acc && !pwrite && paddr == 8'h38 |=>
    !alert_n_oe) else $error("alert kept after response read");
  onoff_follow_a: assert property (enable_input [*8] ##1
    (acc && pwrite && paddr == 8'h20 && open_detect == '0) |=>
    bypass_switch == ~$past(pwdata[7:0])) else $error("switches ignore on/off word");
endmodule : mld_core_asserts
bind mld_core mld_core_asserts #(.NUM_CH(NUM_CH)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pslverr(pslverr), .enable_input(enable_input), .open_detect(open_detect),
  .overheat_detect(overheat_detect), .bypass_switch(bypass_switch),
  .open_threshold_select(open_threshold_select),
  .short_threshold_select(short_threshold_select), .alert_n_oe(alert_n_oe));
`default_nettype wire

/* mld_host.sv */
// host side of the alert line: pull-up resolving the open-drain pull-down
`timescale 1ns/1ps
`default_nettype none
module mld_host (
  // from the core
  input wire logic alert_n_o,
  input wire logic alert_n_oe,
  // line seen by the master
  output logic alert_wire
);
  assign alert_wire = alert_n_oe ? alert_n_o : 1'b1;
endmodule : mld_host
`default_nettype wire

/* mld_core_tb.sv */
// self-checking bench for the matrix led dimmer core
`timescale 1ns/1ps
`default_nettype none
module mld_core_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = '0, od = '0, sd = '0, bsw, r8;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, serr, en = 1'b0, pin = 1'b0, esel = 1'b0, osc = 1'b0, oh = 1'b0;
  logic [1:0] oth [8], sth [8];
  logic ao, aoe, aw;
  logic [15:0] seed = 16'h87fd;
  logic [3:0] asel = 4'ha;
  int err_count = 0, checked = 0, dv;
  mld_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enable_input(en), .pwm_clock_pin(pin), .ext_clock_sel(esel),
    .int_osc_tick(osc), .addr_select(asel), .open_detect(od), .short_detect(sd),
    .overheat_detect(oh), .bypass_switch(bsw), .open_threshold_select(oth),
    .short_threshold_select(sth), .alert_n_o(ao), .alert_n_oe(aoe));
  mld_host host (.alert_n_o(ao), .alert_n_oe(aoe), .alert_wire(aw));
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    osc <= ~osc;
    pin <= ~pin;
  end
  function automatic logic [7:0] lfsr();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction : lfsr
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // switch-on share of a dimming channel is (256 - value) / 256
  function automatic logic near(int on, int v);
    return on * 256 >= (248 - v) * 8192 && on * 256 <= (264 - v) * 8192;
  endfunction : near
  // rising fade steps: grow by a sixteenth, at least one lsb, until the target is met
  function automatic int fade_steps(input int from, input int to);
    int x = from * 8;
    int n = 0;
    while (x < to * 8) begin
      x = (x < 16) ? x + 1 : x + x / 16;
      n++;
    end
    return n;
  endfunction : fade_steps
  task automatic duty(input int ch, input int v);
    int on = 0;
    repeat (4096) @(posedge pclk);
    repeat (8192) begin
      @(posedge pclk);
      on += bsw[ch];
    end
    check(near(on, v), 1'b1, "duty");
  endtask : duty
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    #950_000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, mld_pkg::OFF_CFG0, '0);
    check(rd[13:0], mld_pkg::CFG_RESET, "cfg default");
    apb(1'b0, mld_pkg::OFF_ONOFF, '0);
    check(rd[7:0], mld_pkg::ONOFF_RESET, "onoff default");
    apb(1'b0, 8'h3c, '0);
    check({rd, serr}, {32'h0, 1'b1}, "unmapped");
    apb(1'b1, mld_pkg::OFF_CFG0, 32'h0601);
    apb(1'b0, mld_pkg::OFF_CFG0, '0);
    check({rd[13:0], bsw}, {14'h0601, 8'h0}, "disabled write");
    en <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, mld_pkg::OFF_CFG0, '0);
    check({rd[13:0], bsw}, {mld_pkg::CFG_RESET, 8'h0}, "por");
    r8 = lfsr();
    apb(1'b1, mld_pkg::OFF_ONOFF, {24'h0, r8});
    check(bsw, 8'(~r8), "onoff");
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 8'h04, {18'h0, 4'hc, 2'(m), 8'h01});
      check(bsw, {~r8[7:2], m == 0, ~r8[0]}, "mode");
    end
    dv = 1;
    for (int k = 0; k < 2; k++) begin
      esel <= k[0];
      r8 = 8'(16 + lfsr() % 224);
      apb(1'b1, 8'h08, {18'h0, 4'hc, mld_pkg::MODE_DIM, r8});
      apb(1'b0, 8'h08, '0);
      check(rd[7:0], 8'(dv), "pending");
      apb(1'b1, mld_pkg::OFF_COMMIT, 32'h1);
      dv = r8;
      duty(2, dv);
    end
    apb(1'b1, 8'h14, {18'h0, 4'hc, mld_pkg::MODE_DIM, 8'h80});
    apb(1'b1, mld_pkg::OFF_COMMIT, 32'h1);
    apb(1'b1, 8'h14, {18'h0, 4'hc, mld_pkg::MODE_FADE, 8'h90});
    apb(1'b1, mld_pkg::OFF_COMMIT, 32'h1);
    duty(5, 8'h80);
    repeat (fade_steps(8'h80, 8'h90) * mld_pkg::STEP_CYCLES * mld_pkg::CYCLE_TICKS * 2 - 12288)
      @(posedge pclk);
    duty(5, 8'h90);
    apb(1'b1, 8'h0c, {18'h0, 4'hc, mld_pkg::MODE_ON, 8'h01});
    asel <= 4'(lfsr());
    od <= 8'h08;
    sd <= 8'h04;
    oh <= 1'b1;
    repeat (6) @(posedge pclk);
    od <= '0;
    sd <= '0;
    oh <= 1'b0;
    repeat (6) @(posedge pclk);
    check({aw, bsw[3]}, 2'b01, "fault");
    apb(1'b0, mld_pkg::OFF_FLT_OPEN, '0);
    check(rd[7:0], 8'h08, "open flags");
    apb(1'b0, mld_pkg::OFF_FLT_SHORT, '0);
    check(rd[8:0], 9'h104, "short flags");
    duty(2, dv);
    apb(1'b0, mld_pkg::OFF_ARA, '0);
    check(aw, 1'b1, "ara");
    check(rd[7:0], {mld_pkg::ADR_ALL, asel, 1'b1}, "ara address");
    apb(1'b1, mld_pkg::OFF_FLT_CLR, 32'h1ffff);
    apb(1'b0, mld_pkg::OFF_FLT_SHORT, '0);
    check({rd[8:0], bsw[3]}, 10'h0, "cleared");
    en <= 1'b0;
    repeat (8) @(posedge pclk);
    check({aw, bsw}, 9'h100, "shutdown");
    end_of_test();
  end
endmodule : mld_core_tb
`default_nettype wire
